// File: shared/rss_defines.vh
`ifndef RSS_DEFINES_VH
`define RSS_DEFINES_VH
// ==========================================================
// Control bit positions
`define RSS_FFF_BIT        3'd7
`define RSS_DISCH_BIT      3'd6
`define RSS_EN_BIT         3'd5
// ==========================================================
// Reset values
`define RSS_CONV1_RST      8'h20
`define RSS_CONV2_RST      8'h20
`define RSS_LIN_RST        8'h88
`define RSS_UVLO_RST       8'h0D
`define RSS_CORE_V_LO      4'h0
`define RSS_CORE_V_HI      4'h1
// ==========================================================
// Timing, ns, and cycle counts at 4 ns
`define RSS_CLK_NS         4
`define RSS_T_UVLO_NS      400
`define RSS_T_OT_NS        400
`define RSS_T_STEP_NS      200
`define RSS_UVLO_CYC  ((`RSS_T_UVLO_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`define RSS_OT_CYC    ((`RSS_T_OT_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`define RSS_STEP_CYC  ((`RSS_T_STEP_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
// ==========================================================
// Sequencer states
`define RSS_S_OFF          3'd0
`define RSS_S_UP1          3'd1
`define RSS_S_UP2          3'd2
`define RSS_S_ON           3'd3
`define RSS_S_WAIT         3'd4
`define RSS_S_DN1          3'd5
`define RSS_S_DN2          3'd6
`endif

// File: logic/rss_sync.v
// ==========================================================
// Two-flop synchroniser, per bit
module rss_sync #(
  parameter W = 4
) (
  input  wire         mclk,
  input  wire         nrst,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      // First flop feeds only the second
      always @(posedge mclk) begin
        if (!nrst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= d[i];
          s2_q <= s1_q;
        end
      end
      assign q[i] = s2_q;
    end
  endgenerate
endmodule

// File: logic/rss_timer.v
`include "rss_defines.vh"
// ==========================================================
// Down counter: load then pulse done as it steps from one to zero
module rss_timer #(
  parameter W = 12
) (
  input  wire         mclk,
  input  wire         nrst,
  input  wire         load,
  input  wire [W-1:0] count,
  output reg          done
);
  reg [W-1:0] cnt_q;
  // Load has priority; done is a one-cycle pulse
  always @(posedge mclk) begin
    if (!nrst) begin
      cnt_q <= {W{1'b0}};
      done  <= 1'b0;
    end else if (load) begin
      cnt_q <= count;
      done  <= 1'b0;
    end else begin
      done  <= (cnt_q == {{(W-1){1'b0}}, 1'b1});
      if (cnt_q != {W{1'b0}})
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// File: logic/rss_top.v
`include "rss_defines.vh"
// Contract
// - Discharge bits reset off, one per converter
// - Pull-down on when fault-off and bit set
// - Converter power-good flag into status
// - Maskable interrupt on converter rail droop
// - Converter comparator gated while converter off
// - Overtemperature acts only in fixed-frequency mode
// - Linear regulators default on, host-changeable
// - Linear regulator power-good flag into status
// - Interrupt on linear regulator droop
// - Second linear comparator gated while off
// - First linear comparator always active, drives reset
// - Lockout threshold resets to default, writable
// - Undervoltage: fail low, delay, ordered shutdown
// - Overtemperature: same steps, own delay
// - Automatic restart after condition clears
// - Order select picks first-up, last-down converter
// - Core default voltage from select pin
// - Bit 7 forces fixed-frequency mode
// - Power-fail low while power-on reset low
module rss_top #(
  parameter TW = 12
) (
  input  wire       mclk,
  input  wire       nrst,
  input  wire       supply_order_select,
  input  wire       core_default_voltage_select,
  input  wire       battery_cover_sense,
  input  wire       uvlo_below,
  input  wire       overtemp,
  input  wire       high_load_pwm,
  input  wire [3:0] pgood_raw,
  input  wire       wr_conv1,
  input  wire       wr_conv2,
  input  wire       wr_lin,
  input  wire       wr_uvlo,
  input  wire [7:0] wr_data,
  input  wire [7:0] irq_mask,
  output reg  [7:0] converter_ctrl_first,
  output reg  [7:0] converter_ctrl_second,
  output reg  [7:0] linear_regulator_ctrl,
  output reg  [7:0] uvlo_threshold,
  output reg  [3:0] core_voltage_sel,
  output wire [7:0] regulator_status_reg,
  output reg        core_rail_en,
  output reg        main_rail_en,
  output wire       first_linear_en,
  output wire       second_linear_en,
  output reg        core_rail_discharge,
  output reg        main_rail_discharge,
  output wire       fixed_freq_mode,
  output wire [3:0] pgood_cmp_en,
  output reg        power_fail_n,
  output reg        power_on_reset_n,
  output reg        droop_irq
);
  // ========================================================
  // Synchronised comparator inputs
  wire [3:0] pg_s;
  wire [2:0] flt_s;
  rss_sync #(.W(4)) u_pg_sync (
    .mclk (mclk),
    .nrst (nrst),
    .d    (pgood_raw),
    .q    (pg_s)
  );
  rss_sync #(.W(3)) u_flt_sync (
    .mclk (mclk),
    .nrst (nrst),
    .d    ({overtemp, uvlo_below, battery_cover_sense}),
    .q    (flt_s)
  );
  wire cover_ok = flt_s[0];
  wire uv       = flt_s[1];

  // ========================================================
  // Host-written control registers
  reg strap_done_q;
  always @(posedge mclk) begin
    if (!nrst) begin
      converter_ctrl_first  <= `RSS_CONV1_RST;
      converter_ctrl_second <= `RSS_CONV2_RST;
      linear_regulator_ctrl <= `RSS_LIN_RST;
      uvlo_threshold        <= `RSS_UVLO_RST;
      core_voltage_sel      <= `RSS_CORE_V_LO;
      strap_done_q          <= 1'b0;
    end else begin
      // Strap caught once after reset release, not in reset
      if (!strap_done_q) begin
        strap_done_q     <= 1'b1;
        core_voltage_sel <= core_default_voltage_select ?
                            `RSS_CORE_V_HI : `RSS_CORE_V_LO;
      end
      if (wr_conv1)
        converter_ctrl_first  <= wr_data;
      if (wr_conv2)
        converter_ctrl_second <= wr_data;
      if (wr_lin)
        linear_regulator_ctrl <= wr_data;
      if (wr_uvlo)
        uvlo_threshold        <= wr_data;
    end
  end

  // Fixed-frequency either forced or load-driven
  assign fixed_freq_mode = converter_ctrl_first[`RSS_FFF_BIT] |
                           high_load_pwm;
  // Overtemperature ignored outside fixed-frequency mode
  wire ot = flt_s[2] & fixed_freq_mode;
  wire fault = uv | ot | ~cover_ok;
  wire want_core = converter_ctrl_second[`RSS_EN_BIT];
  wire want_main = converter_ctrl_first[`RSS_EN_BIT];

  // ========================================================
  // Comparator enables and status
  assign pgood_cmp_en[0] = core_rail_en;
  assign pgood_cmp_en[1] = main_rail_en;
  assign pgood_cmp_en[2] = 1'b1;
  assign pgood_cmp_en[3] = second_linear_en;

  // A rail just enabled reads good until its comparator result
  // has crossed both sync flops; else each ramp looks like droop
  reg [3:0] cmp_en_d1_q;
  reg [3:0] cmp_en_d2_q;
  always @(posedge mclk) begin
    if (!nrst) begin
      cmp_en_d1_q <= 4'h0;
      cmp_en_d2_q <= 4'h0;
    end else begin
      cmp_en_d1_q <= pgood_cmp_en;
      cmp_en_d2_q <= cmp_en_d1_q;
    end
  end
  // Disabled or still blanked comparator reads good
  wire [3:0] pg_ok = pg_s | ~(pgood_cmp_en & cmp_en_d2_q);
  // Bits 0 to 3: core, main, first linear, second linear
  assign regulator_status_reg = {4'h0, pg_ok};

  // ========================================================
  // Droop interrupt, level from masked falling power-good
  reg [3:0] pg_prev_q;
  reg [3:0] droop_q;
  always @(posedge mclk) begin
    if (!nrst) begin
      pg_prev_q <= 4'hF;
      droop_q   <= 4'h0;
      droop_irq <= 1'b0;
    end else begin
      // Blanked comparators read good, so reset leaves no edge
      pg_prev_q <= pg_ok;
      // New droop wins over mask-based clear
      droop_q   <= (droop_q & irq_mask[7:4]) |
                   (pg_prev_q & ~pg_ok);
      droop_irq <= |(droop_q & ~irq_mask[3:0]);
    end
  end

  // ========================================================
  // Power sequencer
  reg  [2:0]    st_q;
  reg           tmr_load;
  reg  [TW-1:0] tmr_cnt;
  wire          tmr_done;
  reg           fault_off_q;
  reg           lin_on_q;
  rss_timer #(.W(TW)) u_timer (
    .mclk  (mclk),
    .nrst  (nrst),
    .load  (tmr_load),
    .count (tmr_cnt),
    .done  (tmr_done)
  );

  // Cycle counts kept at integer width, trimmed to the timer.
  // Limitation: every count must fit in TW bits
  localparam [31:0] STEP_C = `RSS_STEP_CYC;
  localparam [31:0] UVLO_C = `RSS_UVLO_CYC;
  localparam [31:0] OT_C   = `RSS_OT_CYC;

  // Delay chosen by cause: overtemperature or undervoltage
  always @* begin
    tmr_load = 1'b0;
    tmr_cnt  = STEP_C[TW-1:0];
    case (st_q)
      `RSS_S_OFF: begin
        // Reload every idle cycle so the ramp step starts full
        tmr_load = 1'b1;
      end
      `RSS_S_ON: begin
        if (fault) begin
          tmr_load = 1'b1;
          tmr_cnt  = ot ? OT_C[TW-1:0] : UVLO_C[TW-1:0];
        end
      end
      // Each expiry restarts the step delay for the next rail
      `RSS_S_UP1, `RSS_S_WAIT, `RSS_S_DN1: begin
        tmr_load = tmr_done;
      end
      default: begin
        tmr_load = 1'b0;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (!nrst) begin
      st_q         <= `RSS_S_OFF;
      core_rail_en <= 1'b0;
      main_rail_en <= 1'b0;
      fault_off_q  <= 1'b0;
      lin_on_q     <= 1'b0;
    end else begin
      case (st_q)
        `RSS_S_OFF: begin
          if (!fault) begin
            // Restart without host action
            fault_off_q <= 1'b0;
            lin_on_q    <= 1'b1;
            st_q        <= `RSS_S_UP1;
            if (supply_order_select)
              main_rail_en <= want_main;
            else
              core_rail_en <= want_core;
          end
        end
        `RSS_S_UP1: begin
          if (fault)
            st_q <= `RSS_S_ON;
          else if (tmr_done) begin
            if (supply_order_select)
              core_rail_en <= want_core;
            else
              main_rail_en <= want_main;
            st_q <= `RSS_S_ON;
          end
        end
        `RSS_S_ON: begin
          if (fault)
            st_q <= `RSS_S_WAIT;
          else begin
            core_rail_en <= want_core;
            main_rail_en <= want_main;
          end
        end
        `RSS_S_WAIT: begin
          if (tmr_done) begin
            fault_off_q <= 1'b1;
            st_q        <= `RSS_S_DN1;
            // Last-up goes down first
            if (supply_order_select)
              core_rail_en <= 1'b0;
            else
              main_rail_en <= 1'b0;
          end
        end
        `RSS_S_DN1: begin
          if (tmr_done) begin
            core_rail_en <= 1'b0;
            main_rail_en <= 1'b0;
            st_q         <= `RSS_S_DN2;
          end
        end
        `RSS_S_DN2: begin
          lin_on_q <= 1'b0;
          st_q     <= `RSS_S_OFF;
        end
        default: begin
          st_q <= `RSS_S_OFF;
        end
      endcase
    end
  end

  // Linear regulators follow their control bits while running
  assign first_linear_en  = lin_on_q &
                            linear_regulator_ctrl[3];
  assign second_linear_en = lin_on_q &
                            linear_regulator_ctrl[7];

  // ========================================================
  // Discharge loads and fail outputs
  always @(posedge mclk) begin
    if (!nrst) begin
      core_rail_discharge <= 1'b0;
      main_rail_discharge <= 1'b0;
      power_on_reset_n    <= 1'b0;
      power_fail_n        <= 1'b0;
    end else begin
      // Loads only after a fault shutdown, never a host disable
      core_rail_discharge <= fault_off_q & ~core_rail_en &
        converter_ctrl_second[`RSS_DISCH_BIT];
      main_rail_discharge <= fault_off_q & ~main_rail_en &
        converter_ctrl_first[`RSS_DISCH_BIT];
      // Reset follows first linear regulator alone
      power_on_reset_n    <= pg_s[2];
      // Fail drops at once on fault, and under reset
      power_fail_n        <= ~fault & pg_s[2];
    end
  end
endmodule

// File: tb/rss_rails.sv
// ====
// Rail and comparator model on the far side of the block
module rss_rails (
  input  wire       core_rail_en,
  input  wire       main_rail_en,
  input  wire       first_linear_en,
  input  wire       second_linear_en,
  input  wire [3:0] droop,
  output wire [3:0] pgood_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  // Good only while enabled and not sagging; first linear rail is
  // treated as externally fed so reset can release before ramp-up
  assign pgood_raw = {second_linear_en, 1'b1, main_rail_en,
                      core_rail_en} & ~droop;
endmodule

// File: tb/rss_top_asserts.sv
// ====
// Sequencer port checks
module rss_chk (
  input wire       mclk,
  input wire       nrst,
  input wire       supply_order_select,
  input wire       uvlo_below,
  input wire       high_load_pwm,
  input wire       wr_lin,
  input wire [7:0] wr_data,
  input wire [7:0] irq_mask,
  input wire [3:0] pgood_raw,
  input wire [7:0] converter_ctrl_first,
  input wire [7:0] linear_regulator_ctrl,
  input wire [7:0] uvlo_threshold,
  input wire [7:0] regulator_status_reg,
  input wire       core_rail_en,
  input wire       main_rail_en,
  input wire       second_linear_en,
  input wire       main_rail_discharge,
  input wire       fixed_freq_mode,
  input wire [3:0] pgood_cmp_en,
  input wire       power_fail_n,
  input wire       droop_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // ====
  // Registers and modes
  rst_vals_a: assert property (
    $rose(nrst) |-> converter_ctrl_first == 8'h20 &&
    linear_regulator_ctrl == 8'h88 && uvlo_threshold == 8'h0d)
    else $error("control registers not at reset values");
  lin_wr_a: assert property (
    wr_lin |=> linear_regulator_ctrl == $past(wr_data))
    else $error("linear control write lost");
  ffm_mode_a: assert property (
    fixed_freq_mode == (converter_ctrl_first[7] | high_load_pwm))
    else $error("fixed-frequency mode wrong");
  lin1_cmp_a: assert property (pgood_cmp_en[2])
    else $error("first linear comparator disabled");
  lin2_cmp_a: assert property (
    !second_linear_en |-> !pgood_cmp_en[3])
    else $error("second linear comparator left on");
  // ====
  // Power good and interrupt; sync delay is two edges
  status_sync_a: assert property (
    $fell(pgood_raw[1]) && pgood_cmp_en[1] |=>
    regulator_status_reg[1] ##[1:2] !regulator_status_reg[1])
    else $error("status flag timing wrong");
  droop_irq_a: assert property (
    $fell(pgood_raw[1]) && pgood_cmp_en[1] && !irq_mask[1]
    |-> ##[2:6] droop_irq)
    else $error("droop interrupt missing");
  // ====
  // Fault sequencing
  uv_fail_a: assert property (
    $rose(uvlo_below) |-> ##[1:4] !power_fail_n)
    else $error("power-fail not lowered");
  down_core_a: assert property (
    $fell(core_rail_en) && !supply_order_select |-> !main_rail_en)
    else $error("core rail went down first");
  down_main_a: assert property (
    $fell(main_rail_en) && supply_order_select |-> !core_rail_en)
    else $error("main rail went down first");
  up_order_a: assert property (
    $rose(main_rail_en) && !supply_order_select |-> core_rail_en)
    else $error("main rail came up first");
  disch_on_a: assert property (
    $fell(main_rail_en) && !power_fail_n && converter_ctrl_first[6]
    |-> ##[0:2] main_rail_discharge)
    else $error("main discharge not applied");
endmodule

bind rss_top rss_chk i_rss_chk (.*);

// File: tb/test_rss_top.sv
module test_rss_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Stimulus and observed ports
  logic       mclk, nrst, supply_order_select, core_default_voltage_select;
  logic       battery_cover_sense, uvlo_below, overtemp, high_load_pwm;
  logic       wr_conv1, wr_conv2, wr_lin, wr_uvlo;
  logic [7:0] wr_data, irq_mask;
  logic [3:0] droop;
  wire  [7:0] converter_ctrl_first, converter_ctrl_second;
  wire  [7:0] linear_regulator_ctrl, uvlo_threshold, regulator_status_reg;
  wire  [3:0] core_voltage_sel, pgood_cmp_en, pgood_raw;
  wire        core_rail_en, main_rail_en, first_linear_en, second_linear_en;
  wire        core_rail_discharge, main_rail_discharge, fixed_freq_mode;
  wire        power_fail_n, power_on_reset_n, droop_irq;
  int         n_fail = 0;
  int         checks = 0;

  // Block and the rails it drives
  rss_top i_rss_top (.*);
  rss_rails i_rss_rails (.*);

  // Free-running 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ====
  // Shared tasks
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task close_out;
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Reset held eight cycles with the strap set meanwhile
  task do_reset(input logic strap);
    nrst = 1'b0;
    core_default_voltage_select = strap;
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    repeat (2) @(negedge mclk);
    chk({4'h0, core_voltage_sel}, {7'h0, strap});
    chk(converter_ctrl_first, 8'h20);
    chk(converter_ctrl_second, 8'h20);
    chk(linear_regulator_ctrl, 8'h88);
    chk(uvlo_threshold, 8'h0d);
  endtask

  // One-cycle strobe; index 0..3 picks the register
  task wr(input int k, input logic [7:0] d);
    wr_data = d;
    {wr_uvlo, wr_lin, wr_conv2, wr_conv1} = 4'b0001 << k;
    @(negedge mclk);
    {wr_uvlo, wr_lin, wr_conv2, wr_conv1} = 4'h0;
    @(negedge mclk);
  endtask

  // Bounded wait so a stuck sequencer cannot hang the run
  task wait_on;
    for (int i = 0; i < 500 && !(core_rail_en && main_rail_en); i++)
      @(negedge mclk);
    chk({6'h0, core_rail_en, main_rail_en}, 8'h03);
  endtask

  // ====
  // Scenarios
  task t_regs;
    do_reset(1'b1);
    do_reset(1'b0);
    wr(0, 8'he0);
    chk(converter_ctrl_first, 8'he0);
    chk({7'h0, fixed_freq_mode}, 8'h01);
    wr(0, 8'h60);
    wr(1, 8'h60);
    wr(3, 8'h12);
    chk({7'h0, fixed_freq_mode}, 8'h00);
    chk(converter_ctrl_second, 8'h60);
    chk(uvlo_threshold, 8'h12);
    wr(2, 8'h08);
    repeat (2) @(negedge mclk);
    chk({6'h0, second_linear_en, pgood_cmp_en[3]}, 8'h00);
    wr(2, 8'h88);
    chk(linear_regulator_ctrl, 8'h88);
  endtask

  task t_droop;
    wait_on;
    irq_mask = 8'hf0;
    droop = 4'h2;
    repeat (6) @(negedge mclk);
    chk(regulator_status_reg, 8'h0d);
    chk({7'h0, droop_irq}, 8'h01);
    droop = 4'h0;
    irq_mask = 8'h0f;
    repeat (4) @(negedge mclk);
    chk({7'h0, droop_irq}, 8'h00);
    irq_mask = 8'h8f;
    droop = 4'h8;
    repeat (6) @(negedge mclk);
    chk(regulator_status_reg, 8'h07);
    chk({7'h0, droop_irq}, 8'h00);
    irq_mask = 8'h87;
    repeat (3) @(negedge mclk);
    chk({7'h0, droop_irq}, 8'h01);
    droop = 4'h0;
    irq_mask = 8'h0f;
    repeat (4) @(negedge mclk);
  endtask

  // Overtemperature outside fixed-frequency mode must be ignored
  task t_ot_gate;
    overtemp = 1'b1;
    repeat (10) @(negedge mclk);
    chk({7'h0, power_fail_n}, 8'h01);
    overtemp = 1'b0;
  endtask

  // Fault shutdown in the chosen order, then automatic restart
  task t_fault(input logic order, input logic ot);
    logic last;
    supply_order_select = order;
    wait_on;
    uvlo_below = !ot;
    overtemp = ot;
    high_load_pwm = ot;
    repeat (5) @(negedge mclk);
    chk({6'h0, power_fail_n, core_rail_en}, 8'h01);
    for (int i = 0; i < 800 && (core_rail_en || main_rail_en); i++) begin
      if (core_rail_en != main_rail_en) last = core_rail_en;
      @(negedge mclk);
    end
    chk({7'h0, last}, {7'h0, !order});
    repeat (2) @(negedge mclk);
    chk({7'h0, main_rail_discharge}, 8'h01);
    chk({6'h0, first_linear_en, core_rail_discharge}, 8'h01);
    {uvlo_below, overtemp, high_load_pwm} = 3'b000;
    wait_on;
  endtask

  // Cover removal shuts both converters down onto their loads
  task t_cover;
    battery_cover_sense = 1'b0;
    repeat (300) @(negedge mclk);
    chk({6'h0, core_rail_discharge, main_rail_discharge}, 8'h03);
    battery_cover_sense = 1'b1;
    wait_on;
  endtask

  // First linear rail low pulls reset and power-fail
  task t_por;
    droop = 4'h4;
    repeat (4) @(negedge mclk);
    chk({6'h0, power_on_reset_n, power_fail_n}, 8'h00);
    droop = 4'h0;
    repeat (6) @(negedge mclk);
    chk({6'h0, power_on_reset_n, power_fail_n}, 8'h03);
  endtask

  // Main sequence; order select low suits core-first systems
  initial begin
    {nrst, supply_order_select, core_default_voltage_select} = 3'b000;
    {uvlo_below, overtemp, high_load_pwm, battery_cover_sense} = 4'b0001;
    {wr_conv1, wr_conv2, wr_lin, wr_uvlo} = 4'h0;
    {wr_data, irq_mask, droop} = 20'h0_00f0;
    t_regs;
    t_droop;
    t_ot_gate;
    t_fault(1'b0, 1'b0);
    t_fault(1'b1, 1'b1);
    t_cover;
    t_por;
    close_out;
  end

  // Watchdog sized well above the longest expected run
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    close_out;
  end
endmodule
